// [verilog/arrs_readout_top.sv]
`timescale 1ns/1ps
module arrs_readout_top (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic cs_n,                     // Chip select pin
   input wire logic rd_n,                     // Read strobe pin
   input wire logic wr_n,                     // Write strobe pin
   input wire logic conversion_clock_in,      // Conversion clock pin
   input wire logic [9:0] host_data_port_in,  // Data port, pin level
   output logic [9:0] host_data_port_out,     // Data port, driven value
   output logic host_data_port_oe,            // Data port drive enable
   input wire logic [9:0] conv_sample,        // Digitised value from the analog side
   output logic busy_int,                     // High when idle, low while converting
   output logic [9:0] control_word            // Current control register
);
   // All port logic state
   typedef struct packed {
      logic [1:0] cs_sync;     // Chip select synchroniser
      logic [1:0] rd_sync;     // Read strobe synchroniser
      logic [1:0] wr_sync;     // Write strobe synchroniser
      logic [1:0] ck_sync;     // Conversion clock synchroniser
      logic [9:0] db_sync1;    // Data port first stage
      logic [9:0] db_sync2;    // Data port second stage
      logic rd_prev;           // Delayed read strobe
      logic wr_prev;           // Delayed write strobe
      logic ck_prev;           // Delayed conversion clock
      logic wr_taken;          // A write is in flight
      logic [9:0] ctrl;        // Control register
      logic [9:0] res1;        // First result register
      logic [9:0] res2;        // Second result register
      logic ptr;               // Read pointer, high selects second result
      logic [9:0] dout;        // Word on the data port
      logic busy_int;          // Busy/interrupt output
   } arrs_top_t;

   arrs_top_t s_ff;
   arrs_top_t nxt_s;
   logic cs_lo;
   logic rd_lo;
   logic wr_lo;
   logic wr_fall;
   logic wr_rise;
   logic rd_fall;
   logic paired;

   arrs_conv_if cv();

   // Sequencer for acquisition and conversions
   arrs_sar_core u_core (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .cv(cv.core)
   );

   // Strobe levels and edges after synchronising
   assign cs_lo = ~s_ff.cs_sync[1];
   assign rd_lo = ~s_ff.rd_sync[1];
   assign wr_lo = ~s_ff.wr_sync[1];
   assign wr_fall = s_ff.wr_prev & wr_lo & cs_lo & ~rd_lo;
   assign wr_rise = ~s_ff.wr_prev & ~wr_lo & s_ff.wr_taken;
   assign rd_fall = s_ff.rd_prev & rd_lo & cs_lo & ~wr_lo;
   assign paired = s_ff.ctrl[arrs_pkg::CTRL_PAIR_BIT];

   // Requests to the sequencer
   assign cv.start = wr_rise;
   assign cv.abort = wr_fall | (rd_fall & cv.busy);
   assign cv.paired = paired;
   assign cv.clk_edge = s_ff.ck_sync[1] & ~s_ff.ck_prev;

   // Timing of a write, counted from the pin edge:
   // two synchroniser stages, then the edge stage,
   // so the strobe edge is acted on about three clocks late.
   // The control word lands on that same third clock.
   // Busy is forced idle at the same clock, which aborts
   // whatever the sequencer was doing.
   // The rising write strobe starts acquisition.
   // Timing of a read, counted from the pin edge:
   // the drive enable follows the synchronised strobes,
   // and the data word is loaded on the third clock, one after the enable.
   // A read during a sequence aborts it and shows a fixed
   // invalid word; the pointer is left where it was.
   // Hazard: the conversion clock is sampled as data,
   // so it must run well below half the system clock.
   // Next value of all port state
   always_comb begin
      nxt_s = s_ff;
      // Two-stage synchronisers on every pin
      nxt_s.cs_sync = {s_ff.cs_sync[0], cs_n};
      nxt_s.rd_sync = {s_ff.rd_sync[0], rd_n};
      nxt_s.wr_sync = {s_ff.wr_sync[0], wr_n};
      nxt_s.ck_sync = {s_ff.ck_sync[0], conversion_clock_in};
      nxt_s.db_sync1 = host_data_port_in;
      nxt_s.db_sync2 = s_ff.db_sync1;
      nxt_s.rd_prev = s_ff.rd_sync[1];
      nxt_s.wr_prev = s_ff.wr_sync[1];
      nxt_s.ck_prev = s_ff.ck_sync[1];
      // Write strobe falling: load control, restart pointer
      if (wr_fall) begin
         nxt_s.ctrl = s_ff.db_sync2;
         nxt_s.wr_taken = 1'b1;
         nxt_s.ptr = 1'b0;
      end else if (wr_rise) begin
         nxt_s.wr_taken = 1'b0;
      end
      // Results land as each conversion ends
      if (cv.done1) begin
         nxt_s.res1 = conv_sample;
      end
      if (cv.done2) begin
         nxt_s.res2 = conv_sample;
      end
      // Read strobe falling: choose the word to drive
      if (rd_fall) begin
         if (cv.busy) begin
            nxt_s.dout = arrs_pkg::INVALID_DATA;
         end else if (paired) begin
            nxt_s.dout = s_ff.ptr ? s_ff.res2 : s_ff.res1;
            nxt_s.ptr = ~s_ff.ptr;
         end else begin
            nxt_s.dout = s_ff.res1;
            nxt_s.ptr = 1'b0;
         end
      end
      // Busy/interrupt: forced high by a write, low while sequencing
      if (wr_fall) begin
         nxt_s.busy_int = 1'b1;
      end else if (cv.start) begin
         nxt_s.busy_int = 1'b0;
      end else if (cv.abort | cv.done2 | (cv.done1 & ~paired)) begin
         nxt_s.busy_int = 1'b1;
      end
   end

   // State register
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         // Strobes reset to their idle high level, so no false edge
         s_ff <= '{
            cs_sync: 2'h3,
            rd_sync: 2'h3,
            wr_sync: 2'h3,
            ck_sync: 2'h0,
            db_sync1: 10'h000,
            db_sync2: 10'h000,
            rd_prev: 1'b1,
            wr_prev: 1'b1,
            ck_prev: 1'b0,
            wr_taken: 1'b0,
            ctrl: arrs_pkg::CTRL_RST,
            res1: arrs_pkg::RES_RST,
            res2: arrs_pkg::RES_RST,
            ptr: 1'b0,
            dout: arrs_pkg::RES_RST,
            busy_int: 1'b1
         };
      end else begin
         s_ff <= nxt_s;
      end
   end

   // Port drive only while selected and reading
   assign host_data_port_oe = cs_lo & rd_lo & ~wr_lo;
   assign host_data_port_out = s_ff.dout;
   assign busy_int = s_ff.busy_int;
   assign control_word = s_ff.ctrl;
endmodule // arrs_readout_top

// [verilog/arrs_pkg.sv]
package arrs_pkg;
   // Width of the host data port and result words
   localparam int DATA_W = 10;
   // Control word bit that selects paired sampling
   localparam int CTRL_PAIR_BIT = 6;
   // Control register value after reset
   localparam logic [9:0] CTRL_RST = 10'h000;
   // Result register value after reset
   localparam logic [9:0] RES_RST = 10'h000;
   // Word driven when a read cuts a conversion short
   localparam logic [9:0] INVALID_DATA = 10'h3FF;
   // Acquisition length, in conversion clock cycles (middle of 4.5 to 5.5)
   localparam int ACQ_CONVERSION_CLOCK_IN = 5;
   // Length of one conversion, in conversion clock cycles
   localparam int CONV_CONVERSION_CLOCK_IN = 14;
   // Width of the cycle counter in the sequencer
   localparam int CNT_W = 4;
   localparam logic [3:0] ACQ_LAST = 4'(ACQ_CONVERSION_CLOCK_IN - 1);
   localparam logic [3:0] CONV_LAST = 4'(CONV_CONVERSION_CLOCK_IN - 1);
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_ONE = 4'h1;

   // Sequencer states
   typedef enum logic [1:0] {
      ARRS_IDLE = 2'b00,
      ARRS_ACQ = 2'b01,
      ARRS_CONV1 = 2'b10,
      ARRS_CONV2 = 2'b11
   } arrs_seq_t;
endpackage

// [verilog/arrs_conv_if.sv]
`timescale 1ns/1ps
interface arrs_conv_if;
   logic start;    // Begin acquisition and conversions
   logic abort;    // Stop any sequence at once
   logic paired;   // Run a second conversion after the first
   logic clk_edge; // One ref_clk cycle per conversion clock rising edge
   logic busy;     // Sequence in progress
   logic done1;    // First conversion finished this cycle
   logic done2;    // Second conversion finished this cycle

   modport ctl(output start, output abort, output paired, output clk_edge,
               input busy, input done1, input done2);
   modport core(input start, input abort, input paired, input clk_edge,
                output busy, output done1, output done2);
endinterface

// [verilog/arrs_sar_core.sv]
`timescale 1ns/1ps
module arrs_sar_core (
   input wire logic ref_clk,
   input wire logic nrst,
   arrs_conv_if.core cv
);
   // All sequencer state
   typedef struct packed {
      arrs_pkg::arrs_seq_t st;
      logic [3:0] cnt;
   } arrs_core_t;

   arrs_core_t s_ff;
   arrs_core_t nxt_s;
   logic nxt_done1;
   logic nxt_done2;

   // Next state: acquire, then one or two conversions
   always_comb begin
      nxt_s = s_ff;
      nxt_done1 = 1'b0;
      nxt_done2 = 1'b0;
      if (cv.abort) begin
         // Abort beats everything
         nxt_s.st = arrs_pkg::ARRS_IDLE;
         nxt_s.cnt = arrs_pkg::CNT_ZERO;
      end else begin
         case (s_ff.st)
            arrs_pkg::ARRS_IDLE: begin
               // Wait for the write strobe to rise
               if (cv.start) begin
                  nxt_s.st = arrs_pkg::ARRS_ACQ;
                  nxt_s.cnt = arrs_pkg::CNT_ZERO;
               end
            end
            arrs_pkg::ARRS_ACQ: begin
               // Track the inputs for the acquisition time
               if (cv.clk_edge) begin
                  if (s_ff.cnt == arrs_pkg::ACQ_LAST) begin
                     nxt_s.st = arrs_pkg::ARRS_CONV1;
                     nxt_s.cnt = arrs_pkg::CNT_ZERO;
                  end else begin
                     nxt_s.cnt = s_ff.cnt + arrs_pkg::CNT_ONE;
                  end
               end
            end
            arrs_pkg::ARRS_CONV1: begin
               // First conversion
               if (cv.clk_edge) begin
                  if (s_ff.cnt == arrs_pkg::CONV_LAST) begin
                     nxt_done1 = 1'b1;
                     nxt_s.cnt = arrs_pkg::CNT_ZERO;
                     nxt_s.st = cv.paired ? arrs_pkg::ARRS_CONV2 : arrs_pkg::ARRS_IDLE;
                  end else begin
                     nxt_s.cnt = s_ff.cnt + arrs_pkg::CNT_ONE;
                  end
               end
            end
            default: begin
               // Second conversion of a pair
               if (cv.clk_edge) begin
                  if (s_ff.cnt == arrs_pkg::CONV_LAST) begin
                     nxt_done2 = 1'b1;
                     nxt_s.cnt = arrs_pkg::CNT_ZERO;
                     nxt_s.st = arrs_pkg::ARRS_IDLE;
                  end else begin
                     nxt_s.cnt = s_ff.cnt + arrs_pkg::CNT_ONE;
                  end
               end
            end
         endcase
      end
   end

   // Status back to the port logic
   assign cv.busy = (s_ff.st != arrs_pkg::ARRS_IDLE);
   assign cv.done1 = nxt_done1;
   assign cv.done2 = nxt_done2;

   // State register
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s_ff <= '{st: arrs_pkg::ARRS_IDLE, cnt: arrs_pkg::CNT_ZERO};
      end else begin
         s_ff <= nxt_s;
      end
   end
endmodule // arrs_sar_core

// [tb/arrs_readout_props.sv]
`timescale 1ns/1ps
module arrs_readout_props (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic conversion_clock_in,
   input wire logic [9:0] host_data_port_in,
   input wire logic [9:0] host_data_port_out,
   input wire logic host_data_port_oe,
   input wire logic busy_int,
   input wire logic [9:0] control_word
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   logic cc_q_ff; // Last conversion clock level
   logic [5:0] edges_ff; // Clock edges while busy
   logic hit_ff; // Strobe seen while busy
   logic [5:0] exp_edges; // Edges of a full sequence
   assign exp_edges = 6'(arrs_pkg::ACQ_CONVERSION_CLOCK_IN + arrs_pkg::CONV_CONVERSION_CLOCK_IN * (control_word[arrs_pkg::CTRL_PAIR_BIT] ? 2 : 1));
   // Count raw clock edges over one busy stretch
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cc_q_ff <= 1'b0;
         edges_ff <= '0;
         hit_ff <= 1'b0;
      end else begin
         cc_q_ff <= conversion_clock_in;
         edges_ff <= busy_int ? 6'h00 : edges_ff + 6'(conversion_clock_in && !cc_q_ff);
         hit_ff <= !busy_int && (hit_ff || !rd_n || !wr_n);
      end
   end
   cs_idle_a: assert property (cs_n [*3] |-> !host_data_port_oe) else $error("port driven without select");
   rd_idle_a: assert property (rd_n [*3] |-> !host_data_port_oe) else $error("port driven without read");
   read_drive_a: assert property ((!cs_n && !rd_n && wr_n) [*4] |-> host_data_port_oe) else $error("read not driven");
   write_load_a: assert property ($fell(wr_n) && !cs_n && rd_n ##1 (!cs_n && rd_n && !wr_n && $stable(host_data_port_in)) [*5]
      |-> control_word == host_data_port_in) else $error("control word not loaded");
   write_idle_a: assert property ($fell(wr_n) && !cs_n && rd_n ##1 (!cs_n && !wr_n) [*5] |-> busy_int)
      else $error("write left busy low");
   read_abort_a: assert property (!busy_int && !cs_n && wr_n && $fell(rd_n) ##1 (!cs_n && !rd_n) [*5]
      |-> busy_int && host_data_port_out == arrs_pkg::INVALID_DATA) else $error("read abort wrong");
   seq_length_a: assert property ($rose(busy_int) && !hit_ff |-> edges_ff + 6'h01 >= exp_edges && edges_ff <= exp_edges + 6'h01)
      else $error("sequence length wrong");
   start_after_a: assert property ($fell(busy_int) |-> wr_n && $past(wr_n, 2)) else $error("start before write rise");
   write_c: cover property ($fell(wr_n) && !cs_n);
   pair_c: cover property ($rose(busy_int) && control_word[arrs_pkg::CTRL_PAIR_BIT] && !hit_ff);
   abort_c: cover property (!busy_int && $fell(rd_n) && !cs_n);
endmodule // arrs_readout_props
bind arrs_readout_top arrs_readout_props u_props (.ref_clk(ref_clk), .nrst(nrst), .cs_n(cs_n), .rd_n(rd_n),
   .wr_n(wr_n), .conversion_clock_in(conversion_clock_in), .host_data_port_in(host_data_port_in),
   .host_data_port_out(host_data_port_out), .host_data_port_oe(host_data_port_oe), .busy_int(busy_int),
   .control_word(control_word));

// [tb/arrs_host_model.sv]
`timescale 1ns/1ps
module arrs_host_model (
   input wire logic ref_clk,
   input wire logic busy_int,
   input wire logic [9:0] dut_out,
   input wire logic dut_oe,
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic [9:0] pin
);
   logic drv = 1'b0; // Host drives the port
   logic [9:0] val = 10'h000; // Host drive value
   logic [9:0] last_ff = 10'h000; // Previous port level
   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
   end
   // Undriven port shows a changing pattern
   assign pin = dut_oe ? dut_out : (drv ? val : ~last_ff);
   always @(posedge ref_clk) last_ff <= pin;
   // Write cycle, strobe held n cycles
   task automatic host_write(input logic [9:0] v, input int n);
      @(posedge ref_clk);
      cs_n <= 1'b0;
      drv <= 1'b1;
      val <= v;
      @(posedge ref_clk);
      wr_n <= 1'b0;
      repeat (n) @(posedge ref_clk);
      wr_n <= 1'b1;
      @(posedge ref_clk);
      cs_n <= 1'b1;
      drv <= 1'b0;
   endtask
   // Read cycle, normally waiting for idle
   task automatic host_read(input logic sel, input logic wait_idle, output logic [9:0] d, output logic oe);
      int i;
      i = 0;
      while (wait_idle && busy_int !== 1'b1 && i < 2000) begin
         @(posedge ref_clk);
         i++;
      end
      @(posedge ref_clk);
      cs_n <= !sel;
      @(posedge ref_clk);
      rd_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      d = pin;
      oe = dut_oe;
      rd_n <= 1'b1;
      @(posedge ref_clk);
      cs_n <= 1'b1;
   endtask
endmodule // arrs_host_model

// [tb/adc_result_readout_sequencer_test.sv]
`timescale 1ns/1ps
module adc_result_readout_sequencer_test;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic conversion_clock_in = 1'b0;
   logic cs_n, rd_n, wr_n, oe, busy_int, roe;
   logic [9:0] pin, dout, control_word, rd;
   logic [9:0] conv_sample = 10'h000;
   int errors = 0, total_checks = 0, cyc = 0;
   always #20 ref_clk = ~ref_clk;
   // Conversion clock at one eighth rate, plus timeout
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc % 4 == 3) conversion_clock_in <= ~conversion_clock_in;
      if (cyc == 20000) begin
         errors++;
         print_verdict();
      end
   end
   arrs_readout_top u_dut (.ref_clk(ref_clk), .nrst(nrst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
      .conversion_clock_in(conversion_clock_in), .host_data_port_in(pin), .host_data_port_out(dout),
      .host_data_port_oe(oe), .conv_sample(conv_sample), .busy_int(busy_int), .control_word(control_word));
   arrs_host_model u_host (.ref_clk(ref_clk), .busy_int(busy_int), .dut_out(dout), .dut_oe(oe),
      .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .pin(pin));
   // Compare one value
   task automatic check_val(input logic [9:0] got, input logic [9:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Idle read, compare word and drive
   task automatic read_exp(input logic [9:0] exp);
      u_host.host_read(1'b1, 1'b1, rd, roe);
      check_val(rd, exp);
      check_val(10'(roe), 10'h001);
   endtask
   // Start a sequence, optionally abort by a second write
   task automatic run_seq(input logic [9:0] ctrl, input logic [9:0] a, input logic [9:0] b, input logic ab);
      int i;
      conv_sample <= a;
      u_host.host_write(ctrl, 6);
      if (ab) begin
         repeat (60) @(posedge ref_clk);
         u_host.host_write(ctrl, 6);
         check_val(10'(busy_int), 10'h001);
      end
      repeat (200) @(posedge ref_clk);
      check_val(10'(busy_int), 10'(!ctrl[arrs_pkg::CTRL_PAIR_BIT]));
      conv_sample <= b;
      for (i = 0; i < 400 && busy_int !== 1'b1; i++) @(posedge ref_clk);
      check_val(control_word, ctrl);
   endtask
   task automatic t_single();
      run_seq(10'h005, 10'h123, 10'h3C0, 1'b0);
      repeat (3) read_exp(10'h123);
   endtask
   task automatic t_paired();
      run_seq(10'h045, 10'h155, 10'h2AA, 1'b0);
      read_exp(10'h155);
      read_exp(10'h2AA);
      read_exp(10'h155);
      run_seq(10'h045, 10'h0F0, 10'h30F, 1'b0);
      read_exp(10'h0F0);
      read_exp(10'h30F);
   endtask
   task automatic t_abort_wr();
      run_seq(10'h045, 10'h1AB, 10'h254, 1'b1);
      read_exp(10'h1AB);
      read_exp(10'h254);
   endtask
   task automatic t_abort_rd();
      conv_sample <= 10'h0C3;
      u_host.host_write(10'h005, 6);
      repeat (60) @(posedge ref_clk);
      u_host.host_read(1'b1, 1'b0, rd, roe);
      check_val(rd, arrs_pkg::INVALID_DATA);
      check_val(10'(busy_int), 10'h001);
      read_exp(10'h1AB);
   endtask
   task automatic t_cs_high();
      u_host.host_read(1'b0, 1'b1, rd, roe);
      check_val(10'(roe), 10'h000);
   endtask
   // Verdict and end of run
   task automatic print_verdict();
      if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge ref_clk);
      t_single();
      t_paired();
      t_abort_wr();
      t_abort_rd();
      t_cs_high();
      print_verdict();
   end
endmodule // adc_result_readout_sequencer_test
